// file: mdds_diag_bank.sv
// Dual-axis driver diagnostic status bank with power stage supervision

//Contract
// - One diagnostic status word per axis, at two separate addresses.
// - Bit 31 reads one whenever the motor rests, in every mode.
// - Bit 30 flags open load on phase B, bit 29 on phase A.
// - Open load flags only inform; they never alter the driver.
// - Ground short sets bit 28 or 27 and disables that power stage.
// - Ground short flags hold until off time zero or enable pin released.
// - Bit 26 shows shared thermal prewarning in both words.
// - Bit 25 thermal limit disables both stages until prewarning clears too.
// - Thermal shutdown is one shared condition shown alike in both words.
// - Bit 24 flags stall: load value zero while moving, or load speed mode stall.
// - Bits 20 to 16 show the current scaling value in use.
// - Bit 15 reads one while the driver runs in full step.
// - Bits 9 to 0 hold the load value; zero means highest load.
// - At rest the load field shows coil A chopper on time.
module mdds_diag_bank
    import mdds_pkg::*;
(
    input  wire logic                          i_clock,
    input  wire logic                          i_nrst,
    input  wire logic [ADDR_W-1:0]             i_addr,
    input  wire logic [DATA_W-1:0]             i_wdata,
    input  wire logic                          i_write,
    input  wire logic                          i_read,
    output wire logic [DATA_W-1:0]             o_rdata,
    input  wire mdds_axis_in_t [NUM_AXES-1:0]  i_axis,
    input  wire logic                          i_temp_prewarn,
    input  wire logic                          i_temp_limit,
    input  wire logic                          i_driver_enable_neg_pin,
    output wire logic [NUM_AXES-1:0]           o_stage_enable,
    output wire logic [NUM_AXES-1:0][OFFT_W-1:0] o_chopper_off_time,
    output wire logic                          o_irq
);
    mdds_bank_state_t state;
    mdds_bank_state_t next_state;

    wire logic [SYNC_W-1:0] pins_sync;
    wire logic              enn_s;
    wire logic              prewarn_s;
    wire logic              limit_s;
    wire logic              next_over_temp;

    wire mdds_axis_state_t  axis_next [NUM_AXES];
    wire logic [NUM_AXES-1:0] evt_short;
    wire logic [NUM_AXES-1:0] evt_stall;
    wire logic              evt_over_temp;
    wire logic              evt_prewarn;
    wire logic [EVT_W-1:0]  events;

    wire logic              irq_clear_wr;
    wire logic              irq_enable_wr;
    wire logic              cnt_clear_wr;
    wire logic [EVT_W-1:0]  irq_status;
    wire logic [EVT_W-1:0]  irq_enable;

    // Pins and thermal comparators sit outside the clock domain
    mdds_sync u_sync (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_async ({i_temp_limit, i_temp_prewarn, i_driver_enable_neg_pin}),
        .o_sync  (pins_sync)
    );

    assign enn_s     = pins_sync[SYNC_ENN];
    assign prewarn_s = pins_sync[SYNC_PREWARN];
    assign limit_s   = pins_sync[SYNC_LIMIT];

    assign irq_clear_wr  = i_write & (i_addr == REG_IRQ_CLEAR);
    assign irq_enable_wr = i_write & (i_addr == REG_IRQ_ENABLE);
    assign cnt_clear_wr  = i_write & (i_addr == REG_FAULT_CNT);

    mdds_irq u_irq (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_event     (events),
        .i_clear_wr  (irq_clear_wr),
        .i_enable_wr (irq_enable_wr),
        .i_wdata     (i_wdata[EVT_W-1:0]),
        .o_status    (irq_status),
        .o_enable    (irq_enable),
        .o_irq       (o_irq)
    );

    // Limit sets; flag holds while prewarning persists, so both must clear
    assign next_over_temp = limit_s | (state.over_temp & prewarn_s);

    function automatic mdds_axis_state_t axis_step(
        input mdds_axis_state_t  cur,
        input mdds_axis_in_t     in,
        input logic              driver_enable_neg_pin,
        input logic              ot,
        input logic              pw,
        input logic              ctrl_wr,
        input logic [OFFT_W-1:0] wdata,
        input logic              cnt_clr
    );
        mdds_axis_state_t nx;
        logic             drv_on;
        logic             any_short;
        logic             new_short;
        nx        = cur;
        drv_on    = (cur.off_time != OFFT_DISABLED) & ~driver_enable_neg_pin;
        if (ctrl_wr) begin
            nx.off_time = wdata;
        end

        // Detection only latches while powered; disabling is the only clear
        nx.short_a = drv_on & (cur.short_a | in.gnd_short_a);
        nx.short_b = drv_on & (cur.short_b | in.gnd_short_b);
        any_short  = nx.short_a | nx.short_b;
        new_short  = any_short & ~(cur.short_a | cur.short_b);

        // At rest the load field carries on time, so zero is no stall there
        nx.stall = (~in.standstill & (in.load_measure_value == '0))
                 | (in.load_speed_mode & in.speed_stall);

        // Open load inputs deliberately do not reach the stage machine
        unique case (cur.stage)
            STAGE_OFF: begin
                if (drv_on & ~ot) begin
                    nx.stage = STAGE_ON;
                end
            end
            STAGE_ON: begin
                if (!drv_on) begin
                    nx.stage = STAGE_OFF;
                end else if (any_short) begin
                    nx.stage = STAGE_SHORT;
                end else if (ot) begin
                    nx.stage = STAGE_THERMAL;
                end
            end
            STAGE_SHORT: begin
                if (!drv_on) begin
                    nx.stage = STAGE_OFF;
                end
            end
            STAGE_THERMAL: begin
                if (!ot) begin
                    nx.stage = drv_on ? STAGE_ON : STAGE_OFF;
                end
            end
            default: begin
                nx.stage = STAGE_OFF;
            end
        endcase
        nx.stage_en = (nx.stage == STAGE_ON) & ~any_short & ~ot;

        // Saturating count; a short in the clear cycle still counts
        if (cnt_clr) begin
            nx.fault_cnt = new_short ? CNT_ONE : '0;
        end else if (new_short && (cur.fault_cnt != CNT_MAX)) begin
            nx.fault_cnt = cur.fault_cnt + CNT_ONE;
        end

        nx.word                     = '0;
        nx.word[BIT_STANDSTILL]     = in.standstill;
        nx.word[BIT_OPEN_B]         = in.open_load_b;
        nx.word[BIT_OPEN_A]         = in.open_load_a;
        nx.word[BIT_SHORT_B]        = nx.short_b;
        nx.word[BIT_SHORT_A]        = nx.short_a;
        nx.word[BIT_PREWARN]        = pw;
        nx.word[BIT_OVERTEMP]       = ot;
        nx.word[BIT_STALL]          = nx.stall;
        nx.word[CS_MSB:CS_LSB]      = in.current_scale;
        nx.word[BIT_FULL_STEP]      = in.full_step;
        nx.word[LOAD_MSB:LOAD_LSB]  = in.standstill ? in.on_time_a
                                                    : in.load_measure_value;
        return nx;
    endfunction

    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
        wire logic ctrl_hit;

        assign ctrl_hit = i_write & (i_addr == REG_CTRL_ADDR[g]);

        // Both axes see the same registered thermal flags
        assign axis_next[g] = axis_step(
            state.axis[g],
            i_axis[g],
            enn_s,
            state.over_temp,
            state.prewarn,
            ctrl_hit,
            i_wdata[OFFT_W-1:0],
            cnt_clear_wr
        );

        assign evt_short[g] = (axis_next[g].short_a | axis_next[g].short_b)
                            & ~(state.axis[g].short_a | state.axis[g].short_b);
        assign evt_stall[g] = axis_next[g].stall & ~state.axis[g].stall;

        assign o_stage_enable[g]     = state.axis[g].stage_en;
        assign o_chopper_off_time[g] = state.axis[g].off_time;
    end

    assign evt_over_temp = next_over_temp & ~state.over_temp;
    assign evt_prewarn   = prewarn_s & ~state.prewarn;
    assign events        = {evt_prewarn, evt_over_temp, evt_stall, evt_short};

    // Pure selection, so a read can never disturb a flag
    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr,
        input mdds_bank_state_t  s,
        input logic [EVT_W-1:0]  st,
        input logic [EVT_W-1:0]  en
    );
        logic [DATA_W-1:0] r;
        r = '0;
        case (addr)
            REG_DIAG_M1: begin
                r = s.axis[0].word;
            end
            REG_DIAG_M2: begin
                r = s.axis[1].word;
            end
            REG_CTRL_M1: begin
                r = {{(DATA_W-OFFT_W){1'b0}}, s.axis[0].off_time};
            end
            REG_CTRL_M2: begin
                r = {{(DATA_W-OFFT_W){1'b0}}, s.axis[1].off_time};
            end
            REG_IRQ_STATUS: begin
                r = {{(DATA_W-EVT_W){1'b0}}, st};
            end
            REG_IRQ_ENABLE: begin
                r = {{(DATA_W-EVT_W){1'b0}}, en};
            end
            REG_STAGE: begin
                r = {24'h000000, s.axis[1].stage, s.axis[0].stage};
            end
            REG_FAULT_CNT: begin
                r = {16'h0000, s.axis[1].fault_cnt, s.axis[0].fault_cnt};
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    always_comb begin
        next_state = state;
        for (int i = 0; i < NUM_AXES; i++) begin
            next_state.axis[i] = axis_next[i];
        end
        next_state.over_temp = next_over_temp;
        next_state.prewarn   = prewarn_s;
        // Data stands only in the cycle after the strobe
        if (i_read) begin
            next_state.rdata = read_mux(i_addr, state, irq_status, irq_enable);
        end else begin
            next_state.rdata = '0;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= BANK_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
endmodule

// file: mdds_pkg.sv
// Shared constants, types and reset values of the diagnostic status bank
package mdds_pkg;
    localparam int NUM_AXES = 2;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int OFFT_W   = 4;
    localparam int EVT_W    = 6;
    localparam int CNT_W    = 8;
    localparam int SYNC_W   = 3;

    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h40;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h41;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h42;
    localparam logic [ADDR_W-1:0] REG_STAGE      = 8'h43;
    localparam logic [ADDR_W-1:0] REG_FAULT_CNT  = 8'h44;
    localparam logic [ADDR_W-1:0] REG_CTRL_M1    = 8'h6c;
    localparam logic [ADDR_W-1:0] REG_DIAG_M1    = 8'h6f;
    localparam logic [ADDR_W-1:0] REG_CTRL_M2    = 8'h7c;
    localparam logic [ADDR_W-1:0] REG_DIAG_M2    = 8'h7f;
    localparam logic [NUM_AXES-1:0][ADDR_W-1:0] REG_CTRL_ADDR = {REG_CTRL_M2, REG_CTRL_M1};

    localparam int BIT_STANDSTILL = 31;
    localparam int BIT_OPEN_B     = 30;
    localparam int BIT_OPEN_A     = 29;
    localparam int BIT_SHORT_B    = 28;
    localparam int BIT_SHORT_A    = 27;
    localparam int BIT_PREWARN    = 26;
    localparam int BIT_OVERTEMP   = 25;
    localparam int BIT_STALL      = 24;
    localparam int CS_MSB         = 20;
    localparam int CS_LSB         = 16;
    localparam int BIT_FULL_STEP  = 15;
    localparam int LOAD_MSB       = 9;
    localparam int LOAD_LSB       = 0;

    localparam int SYNC_ENN     = 0;
    localparam int SYNC_PREWARN = 1;
    localparam int SYNC_LIMIT   = 2;

    localparam logic [OFFT_W-1:0] OFFT_DISABLED    = 4'h0;
    localparam logic [EVT_W-1:0]  EVT_ENABLE_RESET = 6'h00;
    localparam logic [CNT_W-1:0]  CNT_MAX          = 8'hff;
    localparam logic [CNT_W-1:0]  CNT_ONE          = 8'h01;

    typedef enum logic [3:0] {
        STAGE_OFF     = 4'h1,
        STAGE_ON      = 4'h2,
        STAGE_SHORT   = 4'h4,
        STAGE_THERMAL = 4'h8
    } mdds_stage_t;

    typedef struct packed {
        logic       standstill;
        logic       open_load_a;
        logic       open_load_b;
        logic       gnd_short_a;
        logic       gnd_short_b;
        logic       speed_stall;
        logic       load_speed_mode;
        logic       full_step;
        logic [4:0] current_scale;
        logic [9:0] load_measure_value;
        logic [9:0] on_time_a;
    } mdds_axis_in_t;

    typedef struct packed {
        mdds_stage_t       stage;
        logic              stage_en;
        logic [OFFT_W-1:0] off_time;
        logic              short_a;
        logic              short_b;
        logic              stall;
        logic [CNT_W-1:0]  fault_cnt;
        logic [DATA_W-1:0] word;
    } mdds_axis_state_t;

    typedef struct packed {
        mdds_axis_state_t [NUM_AXES-1:0] axis;
        logic                            over_temp;
        logic                            prewarn;
        logic [DATA_W-1:0]               rdata;
    } mdds_bank_state_t;

    typedef struct packed {
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] enable;
        logic             irq;
    } mdds_irq_state_t;

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
    } mdds_sync_state_t;

    localparam mdds_axis_state_t AXIS_RESET = '{stage: STAGE_OFF, default: '0};
    localparam mdds_bank_state_t BANK_RESET = '{axis: {AXIS_RESET, AXIS_RESET}, default: '0};
    localparam mdds_irq_state_t  IRQ_RESET  = '{enable: EVT_ENABLE_RESET, default: '0};
    // Enable pin idles high so the stages stay off until the pin is seen
    localparam mdds_sync_state_t SYNC_RESET = '{meta: 3'h1, stable: 3'h1};
endpackage

// file: mdds_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs
module mdds_sync
    import mdds_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    input  wire logic [SYNC_W-1:0] i_async,
    output wire logic [SYNC_W-1:0] o_sync
);
    mdds_sync_state_t state;
    mdds_sync_state_t next_state;

    always_comb begin
        next_state        = state;
        next_state.meta   = i_async;
        next_state.stable = state.meta;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= SYNC_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.stable;
endmodule

// file: mdds_irq.sv
// Sticky event status, enable mask and level interrupt
module mdds_irq
    import mdds_pkg::*;
(
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic [EVT_W-1:0] i_event,
    input  wire logic             i_clear_wr,
    input  wire logic             i_enable_wr,
    input  wire logic [EVT_W-1:0] i_wdata,
    output wire logic [EVT_W-1:0] o_status,
    output wire logic [EVT_W-1:0] o_enable,
    output wire logic             o_irq
);
    mdds_irq_state_t state;
    mdds_irq_state_t next_state;

    always_comb begin
        next_state = state;
        // Set beats clear so an event in the clear cycle survives
        next_state.status = (state.status & ~(i_clear_wr ? i_wdata : '0)) | i_event;
        if (i_enable_wr) begin
            next_state.enable = i_wdata;
        end
        next_state.irq = |(next_state.status & next_state.enable);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= IRQ_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_status = state.status;
    assign o_enable = state.enable;
    assign o_irq    = state.irq;
endmodule

// file: mdds_diag_monitor.sv
// Port checker for the diagnostic status bank
module mdds_diag_monitor
    import mdds_pkg::*;
(
    input  wire logic                            i_clock,
    input  wire logic                            i_nrst,
    input  wire logic [ADDR_W-1:0]               i_addr,
    input  wire logic [DATA_W-1:0]               i_wdata,
    input  wire logic                            i_write,
    input  wire logic                            i_read,
    input  wire logic [DATA_W-1:0]               o_rdata,
    input  wire mdds_axis_in_t [NUM_AXES-1:0]    i_axis,
    input  wire logic                            i_temp_prewarn,
    input  wire logic                            i_temp_limit,
    input  wire logic                            i_driver_enable_neg_pin,
    input  wire logic [NUM_AXES-1:0]             o_stage_enable,
    input  wire logic [NUM_AXES-1:0][OFFT_W-1:0] o_chopper_off_time,
    input  wire logic                            o_irq
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    // Six edges cover two sync stages, the flag and the stage register
    sequence s_hot;
        i_temp_limit [*6];
    endsequence
    sequence s_pin_off;
        i_driver_enable_neg_pin [*6];
    endsequence
    sequence s_diag_rd;
        i_read && (i_addr == REG_DIAG_M1 || i_addr == REG_DIAG_M2);
    endsequence

    rdata_idle_a: assert property (!i_read |=> o_rdata == '0)
        else $error("read data seen outside the read slot");
    reserved_zero_a: assert property (
        s_diag_rd |=> o_rdata[23:21] == 3'h0 && o_rdata[14:10] == 5'h00)
        else $error("reserved status bits not zero");
    short_cut_a: assert property (
        (i_axis[0].gnd_short_a || i_axis[0].gnd_short_b) && o_stage_enable[0]
        |=> !o_stage_enable[0])
        else $error("stage kept on after ground short");
    thermal_off_a: assert property (s_hot |-> o_stage_enable == 2'h0)
        else $error("stage on during thermal limit");
    pin_off_a: assert property (s_pin_off |-> o_stage_enable == 2'h0)
        else $error("stage on with enable pin released");
    ctrl_write_a: assert property (
        i_write && i_addr == REG_CTRL_M1
        |=> o_chopper_off_time[0] == $past(i_wdata[OFFT_W-1:0]))
        else $error("axis one off time not written");
    ctrl_write2_a: assert property (
        i_write && i_addr == REG_CTRL_M2
        |=> o_chopper_off_time[1] == $past(i_wdata[OFFT_W-1:0]))
        else $error("axis two off time not written");
    diag_readonly_a: assert property (
        i_write && (i_addr == REG_DIAG_M1 || i_addr == REG_DIAG_M2)
        |=> $stable(o_chopper_off_time))
        else $error("status word write had an effect");
    irq_mask_a: assert property (
        i_write && i_addr == REG_IRQ_ENABLE && i_wdata[EVT_W-1:0] == '0 |-> ##2 !o_irq)
        else $error("interrupt high with all sources masked");
endmodule

bind mdds_diag_bank mdds_diag_monitor u_monitor (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_axis(i_axis),
    .i_temp_prewarn(i_temp_prewarn), .i_temp_limit(i_temp_limit),
    .i_driver_enable_neg_pin(i_driver_enable_neg_pin), .o_stage_enable(o_stage_enable),
    .o_chopper_off_time(o_chopper_off_time), .o_irq(o_irq)
);

// file: test_motor_driver_diag_status.sv
// Directed testbench for the diagnostic status bank
module test_motor_driver_diag_status
    import mdds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                            i_clock, i_nrst, i_write, i_read;
    logic                            pin, warn, limit;
    logic [ADDR_W-1:0]               i_addr;
    logic [DATA_W-1:0]               i_wdata, d;
    mdds_axis_in_t [NUM_AXES-1:0]    ax;
    logic [DATA_W-1:0]               o_rdata;
    logic [NUM_AXES-1:0]             o_stage_enable;
    logic [NUM_AXES-1:0][OFFT_W-1:0] o_off;
    logic                            o_irq;
    int                              num_errors, checks;

    mdds_diag_bank DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_axis(ax), .i_temp_prewarn(warn), .i_temp_limit(limit),
        .i_driver_enable_neg_pin(pin), .o_stage_enable(o_stage_enable),
        .o_chopper_off_time(o_off), .o_irq(o_irq));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    task automatic set_pins(input logic p, input logic w, input logic l);
        @(posedge i_clock);
        pin   <= p;
        warn  <= w;
        limit <= l;
    endtask
    task automatic chk_bits(input logic [1:0] exp, input int hi);
        rd(REG_DIAG_M1);
        chk({30'h0, d[hi-:2]}, {30'h0, exp});
    endtask

    task automatic sc_reset();
        rdchk(REG_DIAG_M1, 32'h8000_0000);
        rdchk(REG_CTRL_M1, 32'h0);
        rdchk(REG_IRQ_ENABLE, 32'h0);
        rdchk(REG_IRQ_STATUS, 32'h0);
        rdchk(8'h00, 32'h0);
        rdchk(REG_STAGE, 32'h11);
        wr(REG_CTRL_M2, 32'hffff_fff9);
        rdchk(REG_CTRL_M2, 32'h9);
        chk({24'h0, o_off}, 32'h90);
        wr(REG_CTRL_M2, 32'h0);
        wr(REG_DIAG_M1, 32'hffff_ffff);
        rdchk(REG_DIAG_M1, 32'h8000_0000);
        chk({24'h0, o_off}, 32'h0);
    endtask

    task automatic sc_fields();
        @(posedge i_clock);
        ax[0] <= '{open_load_b: 1'b1, full_step: 1'b1, current_scale: 5'h15,
                   load_measure_value: 10'h2a5, on_time_a: 10'h1c3, default: '0};
        ax[1] <= '{standstill: 1'b1, open_load_a: 1'b1, current_scale: 5'h0a,
                   on_time_a: 10'h0f0, default: '0};
        tick(2);
        repeat (2) begin
            rdchk(REG_DIAG_M1, 32'h4015_82a5);
            rdchk(REG_DIAG_M2, 32'ha00a_00f0);
        end
    endtask

    task automatic sc_stall();
        @(posedge i_clock);
        ax[0].load_measure_value <= 10'h0;
        tick(2);
        rdchk(REG_DIAG_M1, 32'h4115_8000);
        rdchk(REG_IRQ_STATUS, 32'h4);
        wr(REG_IRQ_ENABLE, 32'h4);
        tick(1);
        chk({31'h0, o_irq}, 32'h1);
        @(posedge i_clock);
        ax[0].load_measure_value <= 10'h2a5;
        ax[0].load_speed_mode    <= 1'b1;
        ax[0].speed_stall        <= 1'b1;
        tick(2);
        rdchk(REG_DIAG_M1, 32'h4115_82a5);
        @(posedge i_clock);
        ax[0].speed_stall <= 1'b0;
        wr(REG_IRQ_ENABLE, 32'h0);
        tick(1);
        chk({31'h0, o_irq}, 32'h0);
        wr(REG_IRQ_CLEAR, 32'h4);
        rdchk(REG_IRQ_STATUS, 32'h0);
    endtask

    task automatic sc_short();
        wr(REG_CTRL_M1, 32'h5);
        tick(3);
        rdchk(REG_STAGE, 32'h12);
        @(posedge i_clock);
        ax[0].open_load_a <= 1'b1;
        tick(2);
        chk({30'h0, o_stage_enable}, 32'h1);
        @(posedge i_clock);
        ax[0].gnd_short_b <= 1'b1;
        @(posedge i_clock);
        ax[0].gnd_short_b <= 1'b0;
        tick(1);
        chk({30'h0, o_stage_enable}, 32'h0);
        chk_bits(2'b10, 28);
        chk_bits(2'b10, 28);
        rdchk(REG_STAGE, 32'h14);
        rdchk(REG_FAULT_CNT, 32'h1);
        wr(REG_CTRL_M1, 32'h0);
        tick(2);
        chk_bits(2'b00, 28);
        wr(REG_CTRL_M1, 32'h5);
        tick(3);
        @(posedge i_clock);
        ax[0].gnd_short_a <= 1'b1;
        @(posedge i_clock);
        ax[0].gnd_short_a <= 1'b0;
        tick(1);
        chk_bits(2'b01, 28);
        set_pins(1'b1, 1'b0, 1'b0);
        tick(5);
        chk_bits(2'b00, 28);
        set_pins(1'b0, 1'b0, 1'b0);
        tick(4);
        chk({30'h0, o_stage_enable}, 32'h1);
        rdchk(REG_IRQ_STATUS, 32'h1);
        rdchk(REG_FAULT_CNT, 32'h2);
        wr(REG_FAULT_CNT, 32'h0);
        rdchk(REG_FAULT_CNT, 32'h0);
    endtask

    task automatic sc_thermal();
        set_pins(1'b0, 1'b1, 1'b0);
        tick(6);
        chk_bits(2'b10, 26);
        rdchk(REG_DIAG_M2, 32'ha40a_00f0);
        chk({30'h0, o_stage_enable}, 32'h1);
        set_pins(1'b0, 1'b1, 1'b1);
        tick(6);
        chk({30'h0, o_stage_enable}, 32'h0);
        chk_bits(2'b11, 26);
        rdchk(REG_DIAG_M2, 32'ha60a_00f0);
        set_pins(1'b0, 1'b1, 1'b0);
        tick(6);
        chk({30'h0, o_stage_enable}, 32'h0);
        set_pins(1'b0, 1'b0, 1'b0);
        tick(6);
        chk({30'h0, o_stage_enable}, 32'h1);
        chk_bits(2'b00, 26);
        // Short m1, overtemp and prewarn events stay sticky
        rdchk(REG_IRQ_STATUS, 32'h31);
    endtask

    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        tick(20000);
        num_errors++;
        give_verdict();
    end

    initial begin
        {i_write, i_read, pin, warn, limit} = '0;
        i_addr  = '0;
        i_wdata = '0;
        ax      = '{default: '{standstill: 1'b1, default: '0}};
        i_nrst  = 1'b0;
        tick(10);
        i_nrst <= 1'b1;
        tick(3);
        sc_reset();
        sc_fields();
        sc_stall();
        sc_short();
        sc_thermal();
        give_verdict();
    end
endmodule
